// ### design/cmpr_if.sv
/*
 * Interfaces between the top and its comparator unit and reference register.
 * Assumes all signals are on aclk.
 */

// ----------------------------------------------------------------------------
// comparator unit link
// ----------------------------------------------------------------------------
interface cmpr_unit_if;
    logic run;
    logic invert;
    logic [1:0] edge_sel;
    logic flag_wr;
    logic flag_wdata;
    logic result;
    logic flag;
    logic irq;
    modport ctrl (output run, output invert, output edge_sel, output flag_wr,
                  output flag_wdata, input result, input flag, input irq);
    modport unit (input run, input invert, input edge_sel, input flag_wr,
                  input flag_wdata, output result, output flag, output irq);
endinterface : cmpr_unit_if

// ----------------------------------------------------------------------------
// reference register link
// ----------------------------------------------------------------------------
interface cmpr_vref_if;
    logic wr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic [15:0] value;
    modport ctrl (output wr, output wdata, output wstrb, input value);
    modport unit (input wr, input wdata, input wstrb, output value);
endinterface : cmpr_vref_if

// ### design/cmpr_pkg.sv
/*
 * Types shared by the comparator control modules.
 * Assumes cmpr_regs.svh for all numeric constants.
 */
package cmpr_pkg;

    // per-comparator writable control fields
    typedef struct packed {
        logic on;
        logic pin_oe;
        logic invert;
        logic [1:0] edge_sel;
        logic pos_sel;
        logic [1:0] neg_sel;
    } cmpr_ctl_type;

    // state of one comparator unit
    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic prev;
        logic armed;
        logic result;
        logic flag;
        logic irq;
    } cmpr_unit_state_type;

    // state of the reference control register
    typedef struct packed {
        logic pos_sel;
        logic [1:0] neg_sel;
        logic power;
        logic pin_drive;
        logic range;
        logic source;
        logic [3:0] level;
    } cmpr_vref_state_type;

    // state of the top: control fields and bus slave
    typedef struct packed {
        cmpr_ctl_type [2:0] ctl;
        logic idle_stop;
        logic [2:0] run;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } cmpr_top_state_type;

endpackage : cmpr_pkg

// ### design/cmpr_regs.svh
/*
 * Register map, field positions and reset values of the comparator and reference block.
 * Assumes an AXI4-Lite slave with 32-bit data and 16-bit registers in the low half-word.
 */
`ifndef CMPR_REGS_SVH
`define CMPR_REGS_SVH

// ----------------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------------
`define CMPR_ADDR_W 8
`define CMPR_OFS_CTL1 8'h00
`define CMPR_OFS_CTL2 8'h04
`define CMPR_OFS_CTL3 8'h08
`define CMPR_OFS_STAT 8'h0c
`define CMPR_OFS_VREF 8'h10

// ----------------------------------------------------------------------------
// comparator_control fields
// ----------------------------------------------------------------------------
`define CMPR_CTL_ON 15
`define CMPR_CTL_PIN_OE 14
`define CMPR_CTL_INVERT 13
`define CMPR_CTL_FLAG 9
`define CMPR_CTL_RESULT 8
`define CMPR_CTL_EDGE_HI 7
`define CMPR_CTL_EDGE_LO 6
`define CMPR_CTL_POS_SEL 4
`define CMPR_CTL_NEG_HI 1
`define CMPR_CTL_NEG_LO 0

// ----------------------------------------------------------------------------
// comparator_module_status fields
// ----------------------------------------------------------------------------
`define CMPR_STAT_IDLE_STOP 15
`define CMPR_STAT_FLAG_LO 8
`define CMPR_STAT_RESULT_LO 0

// ----------------------------------------------------------------------------
// voltage_reference_control fields
// ----------------------------------------------------------------------------
`define CMPR_VREF_POS_SEL 10
`define CMPR_VREF_NEG_HI 9
`define CMPR_VREF_NEG_LO 8
`define CMPR_VREF_POWER 7
`define CMPR_VREF_PIN_DRIVE 6
`define CMPR_VREF_RANGE 5
`define CMPR_VREF_SOURCE 4
`define CMPR_VREF_LEVEL_HI 3
`define CMPR_VREF_LEVEL_LO 0

// ----------------------------------------------------------------------------
// edge select codes, responses, reset values
// ----------------------------------------------------------------------------
`define CMPR_EDGE_NONE 2'h0
`define CMPR_EDGE_RISE 2'h1
`define CMPR_EDGE_FALL 2'h2
`define CMPR_EDGE_ANY 2'h3
`define CMPR_RESP_OKAY 2'h0
`define CMPR_RESP_SLVERR 2'h2
`define CMPR_RST_REG16 16'h0000
`define CMPR_RST_DATA32 32'h0000_0000
`define CMPR_NUM_UNITS 3

`endif

// ### design/cmpr_top.sv
/*
 * Comparator and reference control top: AXI4-Lite register slave, three comparator units,
 * reference control register, idle halt and pin output path.
 * Assumes raw comparator results arrive asynchronously from the analog cores, and
 * idle_mode comes from logic on aclk.
 */
`include "cmpr_regs.svh"

module cmpr_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic idle_mode,
    input wire logic [2:0] comparator_raw,
    output logic [2:0] comparator_on,
    output logic [2:0] positive_input_select,
    output logic [5:0] negative_input_select,
    output logic [2:0] comparator_output_pin,
    output logic [2:0] comparator_output_pin_oe,
    output logic [2:0] event_irq,
    output logic pos_ref_output_select,
    output logic [1:0] neg_ref_output_select,
    output logic ref_ladder_power,
    output logic ref_pin_drive,
    output logic ref_range_select,
    output logic ref_source_select,
    output logic [3:0] ref_level_code
);

    cmpr_pkg::cmpr_top_state_type st_r;
    cmpr_pkg::cmpr_top_state_type st_nxt;
    cmpr_unit_if unit_link[`CMPR_NUM_UNITS] ();
    cmpr_vref_if vref_link ();
    logic [2:0] unit_result;
    logic [2:0] unit_flag;
    logic [2:0] unit_irq;
    logic do_write;
    logic [2:0] ctl_hit;
    logic wr_hit;
    logic [15:0] rd_half;
    logic rd_hit;
    logic [2:0] rd_ctl;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // control register image of one unit, unused bits zero
    function automatic logic [15:0] ctl_image(input cmpr_pkg::cmpr_ctl_type c,
                                               input logic flag, input logic result);
        logic [15:0] v;
        v = `CMPR_RST_REG16;
        v[`CMPR_CTL_ON] = c.on;
        v[`CMPR_CTL_PIN_OE] = c.pin_oe;
        v[`CMPR_CTL_INVERT] = c.invert;
        v[`CMPR_CTL_FLAG] = flag;
        v[`CMPR_CTL_RESULT] = result;
        v[`CMPR_CTL_EDGE_HI:`CMPR_CTL_EDGE_LO] = c.edge_sel;
        v[`CMPR_CTL_POS_SEL] = c.pos_sel;
        v[`CMPR_CTL_NEG_HI:`CMPR_CTL_NEG_LO] = c.neg_sel;
        return v;
    endfunction : ctl_image

    // which control register an address names, one-hot
    function automatic logic [2:0] ctl_decode(input logic [7:0] addr);
        logic [2:0] d;
        d = 3'h0;
        d[0] = (addr == `CMPR_OFS_CTL1);
        d[1] = (addr == `CMPR_OFS_CTL2);
        d[2] = (addr == `CMPR_OFS_CTL3);
        return d;
    endfunction : ctl_decode

    // true for any mapped address
    function automatic logic addr_mapped(input logic [7:0] addr);
        return (|ctl_decode(addr)) || (addr == `CMPR_OFS_STAT) || (addr == `CMPR_OFS_VREF);
    endfunction : addr_mapped

    // ------------------------------------------------------------------------
    // comparator units
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < `CMPR_NUM_UNITS; i++) begin : g_unit
        // unit steering from the control fields
        assign unit_link[i].run = st_r.run[i];
        assign unit_link[i].invert = st_r.ctl[i].invert;
        assign unit_link[i].edge_sel = st_r.ctl[i].edge_sel;
        assign unit_link[i].flag_wr = do_write & ctl_hit[i] & st_r.wstrb[1];
        assign unit_link[i].flag_wdata = st_r.wdata[`CMPR_CTL_FLAG];
        assign unit_result[i] = unit_link[i].result;
        assign unit_flag[i] = unit_link[i].flag;
        assign unit_irq[i] = unit_link[i].irq;

        cmpr_unit u_unit (
            .aclk(aclk),
            .aresetn(aresetn),
            .raw_result(comparator_raw[i]),
            .link(unit_link[i])
        );

        // analog input routing from the stored selects
        assign positive_input_select[i] = st_r.ctl[i].pos_sel;
        assign negative_input_select[2*i+1:2*i] = st_r.ctl[i].neg_sel;
        assign comparator_output_pin_oe[i] = st_r.ctl[i].pin_oe & st_r.run[i];
        // unsynchronised path straight to the pad
        assign comparator_output_pin[i] = comparator_output_pin_oe[i]
                                          & (comparator_raw[i] ^ st_r.ctl[i].invert);
    end

    // ------------------------------------------------------------------------
    // reference register
    // ------------------------------------------------------------------------
    assign vref_link.wr = do_write & (st_r.awaddr == `CMPR_OFS_VREF);
    assign vref_link.wdata = st_r.wdata;
    assign vref_link.wstrb = st_r.wstrb;

    cmpr_vref u_vref (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(vref_link),
        .pos_ref_output_select(pos_ref_output_select),
        .neg_ref_output_select(neg_ref_output_select),
        .ref_ladder_power(ref_ladder_power),
        .ref_pin_drive(ref_pin_drive),
        .ref_range_select(ref_range_select),
        .ref_source_select(ref_source_select),
        .ref_level_code(ref_level_code)
    );

    // ------------------------------------------------------------------------
    // write and read decode
    // ------------------------------------------------------------------------
    always_comb begin
        do_write = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
        ctl_hit = ctl_decode(st_r.awaddr);
        wr_hit = addr_mapped(st_r.awaddr);
        rd_hit = addr_mapped(s_axil_araddr);
        rd_ctl = ctl_decode(s_axil_araddr);
        rd_half = `CMPR_RST_REG16;
        for (int k = 0; k < `CMPR_NUM_UNITS; k++) begin
            if (rd_ctl[k]) begin
                rd_half = ctl_image(st_r.ctl[k], unit_flag[k], unit_result[k]);
            end
        end
        if (s_axil_araddr == `CMPR_OFS_STAT) begin
            rd_half[`CMPR_STAT_IDLE_STOP] = st_r.idle_stop;
            rd_half[`CMPR_STAT_FLAG_LO+2:`CMPR_STAT_FLAG_LO] = unit_flag;
            rd_half[`CMPR_STAT_RESULT_LO+2:`CMPR_STAT_RESULT_LO] = unit_result;
        end
        if (s_axil_araddr == `CMPR_OFS_VREF) begin
            rd_half = vref_link.value;
        end
    end

    // ------------------------------------------------------------------------
    // next state: bus handshakes and control fields
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // address and data taken in either order
        if (s_axil_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axil_wdata[15:0];
            st_nxt.wstrb = s_axil_wstrb[1:0];
        end
        // the write lands once both halves are held
        if (do_write) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_hit ? `CMPR_RESP_OKAY : `CMPR_RESP_SLVERR;
            for (int k = 0; k < `CMPR_NUM_UNITS; k++) begin
                if (ctl_hit[k] && st_r.wstrb[1]) begin
                    st_nxt.ctl[k].on = st_r.wdata[`CMPR_CTL_ON];
                    st_nxt.ctl[k].pin_oe = st_r.wdata[`CMPR_CTL_PIN_OE];
                    st_nxt.ctl[k].invert = st_r.wdata[`CMPR_CTL_INVERT];
                end
                if (ctl_hit[k] && st_r.wstrb[0]) begin
                    st_nxt.ctl[k].edge_sel = st_r.wdata[`CMPR_CTL_EDGE_HI:`CMPR_CTL_EDGE_LO];
                    st_nxt.ctl[k].pos_sel = st_r.wdata[`CMPR_CTL_POS_SEL];
                    st_nxt.ctl[k].neg_sel = st_r.wdata[`CMPR_CTL_NEG_HI:`CMPR_CTL_NEG_LO];
                end
            end
            // only the idle-stop bit of status is writable
            if (st_r.awaddr == `CMPR_OFS_STAT && st_r.wstrb[1]) begin
                st_nxt.idle_stop = st_r.wdata[`CMPR_STAT_IDLE_STOP];
            end
        end
        if (st_r.bvalid && s_axil_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
        st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;
        // read answered one cycle after the address is taken
        if (s_axil_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = {16'h0000, rd_half};
            st_nxt.rresp = rd_hit ? `CMPR_RESP_OKAY : `CMPR_RESP_SLVERR;
        end else if (st_r.rvalid && s_axil_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.arready = ~st_nxt.rvalid;
        // run gate: enabled and not halted by idle
        for (int k = 0; k < `CMPR_NUM_UNITS; k++) begin
            st_nxt.run[k] = st_nxt.ctl[k].on & ~(st_nxt.idle_stop & idle_mode);
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // outputs from flops
    // ------------------------------------------------------------------------
    assign s_axil_awready = st_r.awready;
    assign s_axil_wready = st_r.wready;
    assign s_axil_bvalid = st_r.bvalid;
    assign s_axil_bresp = st_r.bresp;
    assign s_axil_arready = st_r.arready;
    assign s_axil_rvalid = st_r.rvalid;
    assign s_axil_rdata = st_r.rdata;
    assign s_axil_rresp = st_r.rresp;
    assign comparator_on = st_r.run;
    assign event_irq = unit_irq;

endmodule : cmpr_top

// ### design/cmpr_unit.sv
/*
 * One comparator: result synchroniser, polarity, edge detection, event flag, request pulse.
 * Assumes a raw asynchronous result, high when the positive input exceeds the negative.
 */
`include "cmpr_regs.svh"

module cmpr_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic raw_result,
    cmpr_unit_if.unit link
);

    cmpr_pkg::cmpr_unit_state_type st_r;
    cmpr_pkg::cmpr_unit_state_type st_nxt;
    logic rise;
    logic fall;
    logic match;
    logic open_gate;
    logic hit;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync_a = raw_result;
        st_nxt.sync_b = st_r.sync_a;
        st_nxt.prev = st_r.sync_b;
        st_nxt.armed = link.run;
        rise = st_r.sync_b & ~st_r.prev;
        fall = ~st_r.sync_b & st_r.prev;
        // edges on the raw result cover both polarity cases
        unique case (link.edge_sel)
            `CMPR_EDGE_ANY: match = rise | fall;
            `CMPR_EDGE_FALL: match = fall;
            `CMPR_EDGE_RISE: match = rise;
            `CMPR_EDGE_NONE: match = 1'b0;
        endcase
        // a clear in the same cycle as an edge re-arms in time
        open_gate = ~st_r.flag | (link.flag_wr & ~link.flag_wdata);
        hit = link.run & st_r.armed & match & open_gate;
        st_nxt.result = link.run & (st_r.sync_b ^ link.invert);
        if (link.flag_wr) begin
            st_nxt.flag = link.flag_wdata;
        end
        if (hit) begin
            st_nxt.flag = 1'b1;
        end
        st_nxt.irq = hit;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.result = st_r.result;
    assign link.flag = st_r.flag;
    assign link.irq = st_r.irq;

endmodule : cmpr_unit

// ### design/cmpr_vref.sv
/*
 * Voltage reference control register and its analog control outputs.
 * Assumes writes arrive already decoded, with byte strobes for the low half-word.
 */
`include "cmpr_regs.svh"

module cmpr_vref (
    input wire logic aclk,
    input wire logic aresetn,
    cmpr_vref_if.unit link,
    output logic pos_ref_output_select,
    output logic [1:0] neg_ref_output_select,
    output logic ref_ladder_power,
    output logic ref_pin_drive,
    output logic ref_range_select,
    output logic ref_source_select,
    output logic [3:0] ref_level_code
);

    cmpr_pkg::cmpr_vref_state_type st_r;
    cmpr_pkg::cmpr_vref_state_type st_nxt;

    // ------------------------------------------------------------------------
    // byte-lane write
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (link.wr && link.wstrb[1]) begin
            st_nxt.pos_sel = link.wdata[`CMPR_VREF_POS_SEL];
            st_nxt.neg_sel = link.wdata[`CMPR_VREF_NEG_HI:`CMPR_VREF_NEG_LO];
        end
        if (link.wr && link.wstrb[0]) begin
            st_nxt.power = link.wdata[`CMPR_VREF_POWER];
            st_nxt.pin_drive = link.wdata[`CMPR_VREF_PIN_DRIVE];
            st_nxt.range = link.wdata[`CMPR_VREF_RANGE];
            st_nxt.source = link.wdata[`CMPR_VREF_SOURCE];
            st_nxt.level = link.wdata[`CMPR_VREF_LEVEL_HI:`CMPR_VREF_LEVEL_LO];
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // readback with unused bits at zero
    assign link.value = {5'h00, st_r};
    assign pos_ref_output_select = st_r.pos_sel;
    assign neg_ref_output_select = st_r.neg_sel;
    assign ref_ladder_power = st_r.power;
    assign ref_pin_drive = st_r.pin_drive;
    assign ref_range_select = st_r.range;
    assign ref_source_select = st_r.source;
    assign ref_level_code = st_r.level;

endmodule : cmpr_vref

// ### testbench/cmpr_analog_model.sv
/* behavioural analog comparators: result high when the positive input is above
   assumes the bench sets the wanted input relation at clock edges */
module cmpr_analog_model (
    input wire logic [2:0] vin_above,
    output logic [2:0] comparator_raw
);
    timeunit 1ns;
    timeprecision 1ns;
    // settling delay moves result changes between clock edges
    assign #7 comparator_raw = vin_above;
endmodule : cmpr_analog_model

// ### testbench/cmpr_top_props.sv
/* concurrent checks on the comparator control top's ports
   assumes binding to cmpr_top with one clock aclk and reset aresetn */
module cmpr_top_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] comparator_raw,
    input wire logic [2:0] comparator_on,
    input wire logic [2:0] comparator_output_pin,
    input wire logic [2:0] comparator_output_pin_oe,
    input wire logic [2:0] event_irq,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [31:0] s_axil_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic raw_q;
    logic [3:0] since_chg;
    // cycles since the raw result of unit 1 last changed
    always_ff @(posedge aclk) begin
        raw_q <= comparator_raw[0];
        if (!aresetn) since_chg <= 4'hf;
        else if (comparator_raw[0] != raw_q) since_chg <= 4'h0;
        else if (since_chg != 4'hf) since_chg <= since_chg + 4'h1;
    end
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    irq_pulse_a: assert property (event_irq[0] |=> !event_irq[0])
        else $error("event request longer than one cycle");
    irq_cause_a: assert property (event_irq[0] |-> since_chg <= 4'h6)
        else $error("event request without a recent result change");
    off_no_irq_a: assert property (!comparator_on[0] [*3] |-> !event_irq[0])
        else $error("event request from a stopped unit");
    off_no_oe_a: assert property (!comparator_on[0] [*2] |-> !comparator_output_pin_oe[0])
        else $error("pin enabled on a stopped unit");
    pin_gated_a: assert property (!comparator_output_pin_oe[0] |-> !comparator_output_pin[0])
        else $error("pin driven while disabled");
    reset_clear_a: assert property ($rose(aresetn) |-> comparator_on == 3'h0
        && comparator_output_pin_oe == 3'h0)
        else $error("controls not clear after reset");
    upper_zero_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    bvalid_drop_a: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
        else $error("write response held after handshake");
    rvalid_drop_a: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
        else $error("read response held after handshake");
    cover property (event_irq[0]);
    cover property (s_axil_bvalid && s_axil_bready);
    cover property (comparator_output_pin_oe[0] && comparator_output_pin[0]);
endmodule : cmpr_top_props
bind cmpr_top cmpr_top_props u_props (.*);

// ### testbench/testbench.sv
/* self-checking bench for the comparator control top over AXI4-Lite
   assumes the analog model drives the raw results */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, idle_mode = 1'h0;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic [2:0] s_axil_awprot = 3'h0, s_axil_arprot = 3'h0, vin_above = 3'h0;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, d, v;
    logic [3:0] s_axil_wstrb = 4'hf, ref_level_code;
    logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
    logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0, s_axil_awready, s_axil_wready;
    logic s_axil_bvalid, s_axil_arready, s_axil_rvalid, pos_ref_output_select;
    logic [1:0] s_axil_bresp, s_axil_rresp, neg_ref_output_select, r;
    logic [2:0] comparator_raw, comparator_on, positive_input_select, event_irq;
    logic [2:0] comparator_output_pin, comparator_output_pin_oe;
    logic [5:0] negative_input_select;
    logic ref_ladder_power, ref_pin_drive, ref_range_select, ref_source_select;
    int bad_count = 0, checked = 0, cyc = 0, irqs = 0, n0;
    cmpr_top u_dut (.*);
    cmpr_analog_model u_model (.*);
    initial begin
        forever #20 aclk = ~aclk;
    end
    // cycle ceiling and request pulse count
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        irqs <= irqs + $countones(event_irq);
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        logic aw, w, b;
        s_axil_awaddr <= a;
        s_axil_wdata <= x;
        s_axil_awvalid <= 1'h1;
        s_axil_wvalid <= 1'h1;
        s_axil_bready <= 1'h1;
        do begin
            @(negedge aclk);
            aw = s_axil_awready;
            w = s_axil_wready;
            b = s_axil_bvalid;
            r = s_axil_bresp;
            @(posedge aclk);
            if (aw) s_axil_awvalid <= 1'h0;
            if (w) s_axil_wvalid <= 1'h0;
        end while (!b);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ar, rv;
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'h1;
        s_axil_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ar = s_axil_arready;
            rv = s_axil_rvalid;
            d = s_axil_rdata;
            r = s_axil_rresp;
            @(posedge aclk);
            if (ar) s_axil_arvalid <= 1'h0;
        end while (!rv);
    endtask : rd
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            rd(8'(i * 4));
            chk("reset", 32'h0, d);
        end
        for (int i = 0; i < 2; i++) begin
            v = i ? 32'h2a5 : 32'h7ff;
            wr(8'h10, i ? 32'h2a5 : 32'hffff_ffff);
            rd(8'h10);
            chk("vref", v, d);
            chk("vref pins", v, {pos_ref_output_select, neg_ref_output_select,
                ref_ladder_power, ref_pin_drive, ref_range_select, ref_source_select,
                ref_level_code});
        end
        wr(8'h14, 32'h1);
        chk("bresp", 32'h2, r);
        rd(8'h14);
        chk("rresp", 32'h2, r);
        // every edge select with both polarities on unit 1
        for (int e = 0; e < 8; e++) begin
            n0 = irqs;
            wr(8'h00, 32'hc000 | (32'(e[2]) << 13) | (32'(e[1:0]) << 6));
            repeat (4) @(posedge aclk);
            chk("pin low", {3'h1, 2'h0, e[2]},
                {comparator_output_pin_oe, comparator_output_pin});
            vin_above[0] <= 1'h1;
            repeat (10) @(posedge aclk);
            chk("pin high", !e[2], comparator_output_pin[0]);
            chk("rise", e[0], irqs - n0);
            vin_above[0] <= 1'h0;
            repeat (10) @(posedge aclk);
            rd(8'h00);
            chk("flag", e[1:0] != 2'h0, d[9]);
            chk("result", e[2], d[8]);
            chk("pulses", e[1:0] != 2'h0, irqs - n0);
            rd(8'h0c);
            chk("mirror", {e[1:0] != 2'h0, e[2]}, {d[8], d[0]});
            wr(8'h00, 32'h0);
        end
        wr(8'h00, 32'h8000);
        idle_mode <= 1'h1;
        repeat (3) @(posedge aclk);
        chk("idle run", 32'h1, comparator_on);
        wr(8'h0c, 32'h8000);
        rd(8'h0c);
        chk("status", 32'h8000, d);
        chk("idle halt", 32'h0, comparator_on);
        idle_mode <= 1'h0;
        repeat (3) @(posedge aclk);
        chk("resume", 32'h1, comparator_on);
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, 32'(i * 17));
            chk("selects", {i[0], 2'h0, i[1:0], 4'h0},
                {positive_input_select, negative_input_select});
        end
        close_out();
    end
endmodule : testbench
